// ---- pkg/ram_xfer_cfg.svh ----
// Constants for the exchange and transfer execution block
`ifndef RAM_XFER_CFG_SVH
`define RAM_XFER_CFG_SVH
`define OPC_W        10
`define OPC_SWAP_DEC_HI  6'h2f
`define OPC_SWAP_INC_HI  6'h2e
`define OPC_B_TO_ACC     10'h01e
`define OPC_ACC_TO_B     10'h00e
`define OPC_Y_TO_ACC     10'h01f
`define OPC_ACC_TO_Y     10'h00c
`define OPC_LOAD_E       10'h01a
`define OPC_UNLOAD_E     10'h02a
`define OPC_ACC_TO_D     10'h029
`define OPC_D_TO_ACC     10'h051
`define OPC_Z_TO_ACC     10'h053
`define OPC_HI_RANGE     9:4
`define IMM_RANGE        3:0
`define E_HI_RANGE       7:4
`define E_LO_RANGE       3:0
`define D_SRC_RANGE      2:0
`define NIB_ZERO     4'h0
`define NIB_ONE      4'h1
`define NIB_MAX      4'hf
`define BYTE_ZERO    8'h00
`define DR_ZERO      3'h0
`define CARRY_RST    1'b0
`endif

// ---- pkg/ram_xfer_pkg.sv ----
// Types shared by the exchange and transfer execution block
`default_nettype none
package ram_xfer_pkg;
  typedef enum logic [3:0] {
    OP_NONE, OP_SWAP_DEC, OP_SWAP_INC, OP_B_TO_ACC, OP_ACC_TO_B, OP_Y_TO_ACC, OP_ACC_TO_Y,
    OP_LOAD_E, OP_UNLOAD_E, OP_ACC_TO_D, OP_D_TO_ACC, OP_Z_TO_ACC
  } op_t;

  typedef struct packed {
    logic [3:0] acc;
    logic [3:0] b;
    logic [3:0] x;
    logic [3:0] y;
    logic [7:0] e;
    logic [2:0] dr;
  } regs_t;

  typedef struct packed {
    logic       en;
    logic [3:0] data;
  } mem_wr_t;
endpackage : ram_xfer_pkg
`default_nettype wire

// ---- rtl/ram_xfer_exec.sv ----
// Execution of memory exchange and register transfer instructions
`timescale 1ns/1ps
`include "ram_xfer_cfg.svh"
`default_nettype none
module ram_xfer_exec
  import ram_xfer_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 instr_valid,
  input  wire logic [`OPC_W-1:0]    instr,
  input  wire logic [3:0]           mem_rd_data,
  input  wire logic [1:0]           z_reg,
  output logic                      mem_wr_en,
  output logic [3:0]                mem_wr_data,
  output logic                      skip_next,
  output logic                      carry_flag,
  output logic [3:0]                acc,
  output logic [3:0]                b_reg,
  output logic [3:0]                x_reg,
  output logic [3:0]                y_reg,
  output logic [7:0]                e_reg,
  output logic [2:0]                d_ptr
);

  regs_t   st_q, st_d;
  mem_wr_t wr_q, wr_d;
  logic    skip_q, skip_d;
  logic    carry_q;
  op_t     op;
  logic    exec;
  logic [3:0] imm_j;

  assign imm_j = instr[`IMM_RANGE];
  // A skipped slot still consumes its cycle but changes nothing except clearing the pending skip
  assign exec  = instr_valid && !skip_q;

  // Exchanges carry j in the low nibble, so only the upper six bits select them
  always_comb begin
    op = OP_NONE;
    if (instr[`OPC_HI_RANGE] == `OPC_SWAP_DEC_HI) begin
      op = OP_SWAP_DEC;
    end else if (instr[`OPC_HI_RANGE] == `OPC_SWAP_INC_HI) begin
      op = OP_SWAP_INC;
    end else begin
      unique case (instr)
        `OPC_B_TO_ACC: op = OP_B_TO_ACC;
        `OPC_ACC_TO_B: op = OP_ACC_TO_B;
        `OPC_Y_TO_ACC: op = OP_Y_TO_ACC;
        `OPC_ACC_TO_Y: op = OP_ACC_TO_Y;
        `OPC_LOAD_E:   op = OP_LOAD_E;
        `OPC_UNLOAD_E: op = OP_UNLOAD_E;
        `OPC_ACC_TO_D: op = OP_ACC_TO_D;
        `OPC_D_TO_ACC: op = OP_D_TO_ACC;
        `OPC_Z_TO_ACC: op = OP_Z_TO_ACC;
        default:       op = OP_NONE;
      endcase
    end
  end

  always_comb begin
    st_d   = st_q;
    wr_d   = '{en: 1'b0, data: `NIB_ZERO};
    // Any valid slot, executed or dropped, ends a pending skip
    skip_d = instr_valid ? 1'b0 : skip_q;
    if (exec) begin
      unique case (op)
        OP_SWAP_DEC: begin
          wr_d    = '{en: 1'b1, data: st_q.acc};
          st_d.acc = mem_rd_data;
          st_d.x   = st_q.x ^ imm_j;
          st_d.y   = st_q.y - `NIB_ONE;
          skip_d   = (st_q.y - `NIB_ONE) == `NIB_MAX;
        end
        OP_SWAP_INC: begin
          wr_d    = '{en: 1'b1, data: st_q.acc};
          st_d.acc = mem_rd_data;
          st_d.x   = st_q.x ^ imm_j;
          st_d.y   = st_q.y + `NIB_ONE;
          skip_d   = (st_q.y + `NIB_ONE) == `NIB_ZERO;
        end
        OP_B_TO_ACC: st_d.acc = st_q.b;
        OP_ACC_TO_B: st_d.b   = st_q.acc;
        OP_Y_TO_ACC: st_d.acc = st_q.y;
        OP_ACC_TO_Y: st_d.y   = st_q.acc;
        OP_LOAD_E:   st_d.e   = {st_q.b, st_q.acc};
        OP_UNLOAD_E: begin
          st_d.b   = st_q.e[`E_HI_RANGE];
          st_d.acc = st_q.e[`E_LO_RANGE];
        end
        OP_ACC_TO_D: st_d.dr  = st_q.acc[`D_SRC_RANGE];
        // The top accumulator bit is forced low so no stale data leaks through
        OP_D_TO_ACC: st_d.acc = {1'b0, st_q.dr};
        OP_Z_TO_ACC: st_d.acc = {2'b00, z_reg};
        default: ;
      endcase
    end
  end

  // Carry belongs to the arithmetic group; only reset writes it here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= '{acc: `NIB_ZERO, b: `NIB_ZERO, x: `NIB_ZERO, y: `NIB_ZERO,
                   e: `BYTE_ZERO, dr: `DR_ZERO};
      wr_q    <= '{en: 1'b0, data: `NIB_ZERO};
      skip_q  <= 1'b0;
      carry_q <= `CARRY_RST;
    end else begin
      st_q    <= st_d;
      wr_q    <= wr_d;
      skip_q  <= skip_d;
      carry_q <= carry_q;
    end
  end

  assign mem_wr_en   = wr_q.en;
  assign mem_wr_data = wr_q.data;
  assign skip_next   = skip_q;
  assign carry_flag  = carry_q;
  assign acc         = st_q.acc;
  assign b_reg       = st_q.b;
  assign x_reg       = st_q.x;
  assign y_reg       = st_q.y;
  assign e_reg       = st_q.e;
  assign d_ptr       = st_q.dr;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic is_swap_dec, is_swap_inc, is_swap, is_b_to_acc, is_acc_to_b, is_y_to_acc, is_acc_to_y;
  logic is_load_e, is_unload_e, is_acc_to_d, is_d_to_acc, is_z_to_acc, is_noop;
  assign is_swap_dec = exec && op == OP_SWAP_DEC;
  assign is_swap_inc = exec && op == OP_SWAP_INC;
  assign is_swap     = is_swap_dec || is_swap_inc;
  assign is_b_to_acc = exec && op == OP_B_TO_ACC;
  assign is_acc_to_b = exec && op == OP_ACC_TO_B;
  assign is_y_to_acc = exec && op == OP_Y_TO_ACC;
  assign is_acc_to_y = exec && op == OP_ACC_TO_Y;
  assign is_load_e   = exec && op == OP_LOAD_E;
  assign is_unload_e = exec && op == OP_UNLOAD_E;
  assign is_acc_to_d = exec && op == OP_ACC_TO_D;
  assign is_d_to_acc = exec && op == OP_D_TO_ACC;
  assign is_z_to_acc = exec && op == OP_Z_TO_ACC;
  assign is_noop     = exec && op == OP_NONE;

  sequence swap_done_s;
    mem_wr_en && mem_wr_data == $past(acc) && acc == $past(mem_rd_data);
  endsequence

  sequence skipped_slot_s;
    skip_next ##0 instr_valid;
  endsequence

  // Exchanges
  swap_dec_a: assert property (is_swap_dec |=> swap_done_s ##0 x_reg == ($past(x_reg) ^ $past(imm_j)))
    else $error("decrementing exchange did not swap or xor");

  dec_skip_a: assert property (is_swap_dec |=> y_reg == $past(y_reg) - 4'h1 && skip_next == (y_reg == 4'hf))
    else $error("decrementing exchange wrong y or skip");

  swap_inc_a: assert property (is_swap_inc |=> swap_done_s ##0 y_reg == $past(y_reg) + 4'h1)
    else $error("incrementing exchange wrong swap or y");

  inc_skip_a: assert property (is_swap_inc |=> skip_next == (y_reg == 4'h0))
    else $error("incrementing exchange wrong skip");

  swap_keeps_a: assert property (is_swap |=> $stable(b_reg) && $stable(e_reg) && $stable(d_ptr))
    else $error("exchange touched an unrelated register");

  write_source_a: assert property (mem_wr_en |-> $past(is_swap))
    else $error("memory write without an exchange");

  write_idle_a: assert property (!mem_wr_en |-> mem_wr_data == 4'h0)
    else $error("write data not cleared while idle");

  // Register transfers
  copy_acc_a: assert property ((is_b_to_acc |=> acc == $past(b_reg)) and (is_y_to_acc |=> acc == $past(y_reg)))
    else $error("accumulator copy wrong");

  acc_to_b_a: assert property (is_acc_to_b |=> b_reg == $past(acc))
    else $error("b copy wrong");

  acc_to_y_a: assert property (is_acc_to_y |=> y_reg == $past(acc))
    else $error("y copy wrong");

  copy_no_write_a: assert property (exec && !is_swap |=> !mem_wr_en && !skip_next && $stable(x_reg))
    else $error("transfer wrote memory, skipped or changed x");

  e_load_a: assert property (is_load_e |=> e_reg == {$past(b_reg), $past(acc)} && $stable(acc))
    else $error("e load wrong");

  e_unload_a: assert property (is_unload_e |=> b_reg == $past(e_reg[7:4]) && acc == $past(e_reg[3:0]))
    else $error("e unload wrong");

  d_ptr_load_a: assert property (is_acc_to_d |=> d_ptr == $past(acc[2:0]))
    else $error("d pointer load wrong");

  d_ptr_copy_a: assert property (is_d_to_acc |=> acc == {1'b0, $past(d_ptr)})
    else $error("d pointer copy wrong");

  z_copy_a: assert property (is_z_to_acc |=> acc == {2'b00, $past(z_reg)})
    else $error("z copy wrong");

  // Sequencing
  carry_hold_a: assert property ($stable(carry_flag))
    else $error("carry changed");

  skip_once_a: assert property (skipped_slot_s |=> !skip_next && !mem_wr_en && $stable(acc) && $stable(y_reg))
    else $error("skip not single or slot not dropped");

  idle_hold_a: assert property (!instr_valid |=> skip_next == $past(skip_next) && $stable(acc) && $stable(y_reg))
    else $error("idle slot changed state");

  noop_hold_a: assert property (is_noop |=> $stable(acc) && $stable(b_reg) && $stable(e_reg) && $stable(d_ptr))
    else $error("unknown code changed state");

endmodule : ram_xfer_exec
`default_nettype wire

// ---- sim/ram_xfer_exec_tb.sv ----
// Self-checking bench for the exchange and transfer execution block
`timescale 1ns/1ps
`default_nettype none
module ram_xfer_exec_tb import ram_xfer_pkg::*; ;
  // Every transfer code, then both exchanges with j = 0
  localparam logic [9:0] ops [11] = '{10'h01e, 10'h00e, 10'h01f, 10'h00c, 10'h01a, 10'h02a, 10'h029,
                                      10'h051, 10'h053, 10'h2f0, 10'h2e0};
  logic        clk, rst_n, instr_valid, pend, m_skip;
  logic [9:0]  instr, op;
  logic [3:0]  mem_rd_data, mem_wr_data, acc, b_reg, x_reg, y_reg;
  logic [1:0]  z_reg;
  logic        mem_wr_en, skip_next, carry_flag;
  logic [7:0]  e_reg;
  logic [2:0]  d_ptr;
  logic [33:0] exp_q [$];
  logic [33:0] nt, got;
  logic [31:0] seed = 32'h5ee97e0a;
  logic [31:0] r;
  regs_t       m;
  int          failures = 0;
  int          cmp_count = 0;

  ram_xfer_exec i_dut (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .mem_rd_data(mem_rd_data), .z_reg(z_reg), .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data),
    .skip_next(skip_next), .carry_flag(carry_flag), .acc(acc), .b_reg(b_reg), .x_reg(x_reg),
    .y_reg(y_reg), .e_reg(e_reg), .d_ptr(d_ptr));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic check(input string what, input logic [26:0] seen, input logic [26:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, expv, seen);
    end
  endtask : check

  // Drive one slot and note the expected outcome when the slot will execute
  task automatic run(input logic v, input logic [9:0] code);
    @(posedge clk);
    #1;
    instr_valid = v;
    instr = code;
    mem_rd_data = 4'(rnd());
    z_reg = 2'(rnd());
    nt = '0;
    if (v && m_skip) m_skip = 1'b0;
    else if (v) begin
      case (code)
        10'h01e: m.acc = m.b;
        10'h00e: m.b = m.acc;
        10'h01f: m.acc = m.y;
        10'h00c: m.y = m.acc;
        10'h01a: m.e = {m.b, m.acc};
        10'h02a: {m.b, m.acc} = m.e;
        10'h029: m.dr = m.acc[2:0];
        10'h051: m.acc = {1'b0, m.dr};
        10'h053: m.acc = {2'b00, z_reg};
        default: if (code[9:5] == 5'h17) begin
          nt[33:29] = {1'b1, m.acc};
          m.acc = mem_rd_data;
          m.x ^= code[3:0];
          m.y = code[4] ? m.y - 4'h1 : m.y + 4'h1;
          m_skip = (m.y == (code[4] ? 4'hf : 4'h0));
        end
      endcase
      nt[28] = m_skip;
      nt[26:0] = {m.acc, m.b, m.x, m.y, m.e, m.dr};
      exp_q.push_back(nt);
    end
  endtask : run

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  // Results land one edge after the slot is taken; compare at the following falling edge
  always @(posedge clk) pend <= rst_n && instr_valid && !skip_next;
  always @(negedge clk) if (pend) begin
    if (exp_q.size() == 0) check("unexpected execution", 27'h1, 27'h0);
    else begin
      got = exp_q.pop_front();
      check("mem write", {22'h0, mem_wr_en, mem_wr_data}, {22'h0, got[33:29]});
      check("skip", {26'h0, skip_next}, {26'h0, got[28]});
      check("carry", {26'h0, carry_flag}, 27'h0);
      check("registers", {acc, b_reg, x_reg, y_reg, e_reg, d_ptr}, got[26:0]);
    end
  end

  initial begin
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr = '0;
    mem_rd_data = '0;
    z_reg = '0;
    m = '0;
    m_skip = 1'b0;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    @(negedge clk);
    check("reset state", {acc, b_reg, x_reg, y_reg, e_reg, d_ptr}, 27'h0);
    $display("reset test done");
    foreach (ops[i]) run(1'b1, ops[i]);
    // Back-to-back exchanges walk Y through its wrap, so skips drop exchanges too
    repeat (17) run(1'b1, 10'h2e5);
    repeat (17) run(1'b1, 10'h2fa);
    $display("directed test done");
    // Idle slots leave a pending skip; odd codes must act as no-ops
    repeat (3000) begin
      r = rnd();
      op = ops[r[7:0] % 11];
      if (op[9:5] == 5'h17) op[3:0] = r[11:8];
      if (r[17:15] == 3'h0) op = r[27:18];
      run(r[14:12] != 3'h0, op);
    end
    repeat (3) run(1'b0, 10'h000);
    if (exp_q.size() != 0) check("missing execution", 27'h1, 27'h0);
    $display("random test done");
    summarize();
  end
endmodule : ram_xfer_exec_tb
`default_nettype wire
